// File: hw/adc_cmd_pkg.sv
// Package: opcodes, register map, reset values and timing for the command unit
package adc_cmd_pkg;
  // Opcodes
  localparam logic [6:0] OP_WAKE_HI = 7'h00;
  localparam logic [6:0] OP_STANDBY_HI = 7'h01;
  localparam logic [6:0] OP_ALIGN_HI = 7'h02;
  localparam logic [6:0] OP_SRESET_HI = 7'h03;
  localparam logic [7:0] OP_STREAM_ON = 8'h10;
  localparam logic [7:0] OP_STREAM_OFF = 8'h11;
  localparam logic [7:0] OP_SINGLE_READ = 8'h12;
  localparam logic [2:0] OP_REG_READ_CMD_HI = 3'h1;
  localparam logic [2:0] OP_REG_WRITE_CMD_HI = 3'h2;
  localparam logic [7:0] OP_ZERO_TRIM = 8'h60;
  localparam logic [7:0] OP_SPAN_TRIM = 8'h61;
  localparam logic [7:0] OP_REG_READ_CMD_BASE = 8'h20;
  localparam logic [7:0] OP_REG_WRITE_CMD_BASE = 8'h40;
  // Register offsets
  localparam logic [4:0] REG_IDENTITY = 5'h00;
  localparam logic [4:0] REG_FILTER_SETUP = 5'h01;
  localparam logic [4:0] REG_RESERVED_FIXED = 5'h02;
  localparam logic [4:0] REG_OFFSET_LOW = 5'h05;
  localparam logic [4:0] REG_SPAN_LOW = 5'h08;
  localparam logic [4:0] REG_LAST = 5'h0a;
  localparam int NUM_REGS = 11;
  // Identity value, arbitrary
  localparam logic [7:0] IDENTITY_VALUE = 8'h50;
  // Reset values
  localparam logic [8*11-1:0] REG_RESET = {8'h40, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h03, 8'h32, 8'h08, 8'h52, 8'h00};
  // Timing
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int LINK_DIV = 4;
  localparam int BYTE_GAP_CYCLES = 24;
  localparam int WRITE_RESTART_READINGS = 63;
  localparam int TRIM_READINGS = 16;
  localparam int SAMPLE_PERIOD = 2000;
  // Host APB register offsets
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_TXDATA = 8'h04;
  localparam logic [7:0] APB_STATUS = 8'h08;
  localparam logic [7:0] APB_RXDATA = 8'h0c;
  localparam logic [7:0] APB_SAMPLE = 8'h10;
endpackage : adc_cmd_pkg

// File: hw/adc_link_if.sv
// Interface: serial command link between host and converter
`timescale 1ns/1ns
`default_nettype none
interface adc_link_if;
  logic serialClk;
  logic serialIn;
  logic serialOut;
  logic frameSelN;
  logic sampleReadyN;
  logic alignPin;
  logic powerDownPinN;
  logic pinStrapSelect;
  modport device (input serialClk, input serialIn, input frameSelN,
    input alignPin, input powerDownPinN, input pinStrapSelect,
    output serialOut, output sampleReadyN);
  modport host (output serialClk, output serialIn, output frameSelN,
    output alignPin, output powerDownPinN, output pinStrapSelect,
    input serialOut, input sampleReadyN);
endinterface : adc_link_if
`default_nettype wire

// File: hw/sync_edge.sv
// Two-stage synchroniser with rise and fall pulses
`timescale 1ns/1ns
`default_nettype none
module sync_edge (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sync_t;
  sync_t st_q;
  sync_t st_d;
  // Shift chain
  always_comb begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign level = st_q.s2;
  assign rise = st_q.s2 & ~st_q.s3;
  assign fall = ~st_q.s2 & st_q.s3;
endmodule : sync_edge
`default_nettype wire

// File: hw/adc_cmd_device.sv
// Converter end: serial command decoder and register bank
// Functional notes
// - Control opcodes ignore bit zero
// - Exact decode of stream and single read
// - Zero trim updates offset registers
// - Span trim updates span registers
// - Read opcode address byte then count byte
// - Read data starts at sixteenth falling edge
// - Write opcode base 40h, then count
// - Count plus one data bytes stored
// - Host waits 24 cycles between bytes
// - Wake outside standby has no effect
// - Standby keeps registers and port alive
// - Power down pin low loses registers
// - Align restarts conversion sequence
// - Host holds align pin high
// - Soft reset equals hardware reset but keeps data line
// - Stream mode pulses ready per sample
// - Stream off hides ready and data
// - Host stops streaming before reads
// - Registers only when strap low
// - Write restarts, 63 readings suppressed
// - Burst access auto-increments address
// - Decoder idle in pin control mode
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module adc_cmd_device (
  input wire logic sys_clk,
  input wire logic rst,
  adc_link_if.device link,
  input wire logic [23:0] sampleIn,
  output logic standby,
  output logic converting,
  output logic [23:0] offsetWord,
  output logic [23:0] spanWord
);
  typedef enum logic [2:0] {
    PH_OP, PH_COUNT, PH_WDATA, PH_RDATA, PH_SAMPLE, PH_SKIP
  } phase_t;
  typedef struct packed {
    phase_t phase;
    logic [7:0] shiftIn;
    logic [2:0] bitCnt;
    logic [31:0] shiftOut;
    logic [5:0] outBits;
    logic [4:0] addr;
    logic [4:0] left;
    logic isRead;
    logic stream;
    logic sleep;
    logic [15:0] sampleTmr;
    logic [5:0] discard;
    logic [4:0] trimCnt;
    logic trimOfs;
    logic trimSpan;
    logic [23:0] sample;
    logic readyN;
    logic serOut;
    logic conv;
    logic [8*11-1:0] regs;
  } dev_t;
  dev_t st_q;
  dev_t st_d;
  logic clkRise, clkFall;
  logic dinLvl, selLvl, selFall, alignLvl, pdLvl, strapLvl;
  sync_edge u_clk (.sys_clk(sys_clk), .rst(rst), .din(link.serialClk),
    .level(), .rise(clkRise), .fall(clkFall));
  sync_edge u_din (.sys_clk(sys_clk), .rst(rst), .din(link.serialIn),
    .level(dinLvl), .rise(), .fall());
  sync_edge u_sel (.sys_clk(sys_clk), .rst(rst), .din(link.frameSelN),
    .level(selLvl), .rise(), .fall(selFall));
  sync_edge u_aln (.sys_clk(sys_clk), .rst(rst), .din(link.alignPin),
    .level(alignLvl), .rise(), .fall());
  sync_edge u_pd (.sys_clk(sys_clk), .rst(rst), .din(link.powerDownPinN),
    .level(pdLvl), .rise(), .fall());
  sync_edge u_pm (.sys_clk(sys_clk), .rst(rst),
    .din(link.pinStrapSelect), .level(strapLvl), .rise(), .fall());
  logic [7:0] byteIn;
  logic [7:0] rdByte;
  logic byteDone;
  logic restart;
  logic softRst;
  // Byte completion on the eighth rising edge
  always_comb begin
    byteIn = {st_q.shiftIn[6:0], dinLvl};
    byteDone = clkRise && !selLvl && st_q.bitCnt == 3'h7;
    rdByte = (st_q.addr <= adc_cmd_pkg::REG_LAST) ?
      st_q.regs[st_q.addr*8 +: 8] : 8'h00;
  end
  // Main next-state process
  always_comb begin
    st_d = st_q;
    restart = 1'b0;
    softRst = 1'b0;
    if (clkRise && !selLvl) begin
      st_d.shiftIn = byteIn;
      st_d.bitCnt = st_q.bitCnt + 3'h1;
    end
    if (selLvl) begin
      st_d.bitCnt = 3'h0;
    end
    // Shift out on falling edges
    if (clkFall && !selLvl && st_q.outBits != 6'h0) begin
      st_d.serOut = st_q.shiftOut[31];
      st_d.shiftOut = {st_q.shiftOut[30:0], 1'b0};
      st_d.outBits = st_q.outBits - 6'h1;
    end
    // Conversion timer; sleep halts it, registers stay
    if (!st_q.sleep) begin
      st_d.sampleTmr = st_q.sampleTmr + 16'h1;
      st_d.readyN = 1'b1;
      if (st_q.sampleTmr == 16'(adc_cmd_pkg::SAMPLE_PERIOD - 1)) begin
        st_d.sampleTmr = 16'h0;
        st_d.sample = sampleIn;
        if (st_q.discard != 6'h0) begin
          st_d.discard = st_q.discard - 6'h1;
        end else begin
          if (st_q.stream) begin
            st_d.readyN = 1'b0;
            st_d.shiftOut = {sampleIn, 8'h00};
            st_d.outBits = 6'd32;
            st_d.phase = PH_SAMPLE;
          end
          if (st_q.trimOfs || st_q.trimSpan) begin
            st_d.trimCnt = st_q.trimCnt + 5'h1;
          end
        end
      end
    end
    // Trim completion writes the last sample taken
    if (st_q.trimCnt == 5'(adc_cmd_pkg::TRIM_READINGS)) begin
      st_d.trimCnt = 5'h0;
      st_d.trimOfs = 1'b0;
      st_d.trimSpan = 1'b0;
      if (st_q.trimOfs) begin
        st_d.regs[adc_cmd_pkg::REG_OFFSET_LOW*8 +: 24] = st_q.sample;
      end
      if (st_q.trimSpan) begin
        st_d.regs[adc_cmd_pkg::REG_SPAN_LOW*8 +: 24] = st_q.sample;
      end
    end
    // Command decode, only in register mode
    if (byteDone && !strapLvl) begin
      case (st_q.phase)
        PH_OP, PH_SAMPLE, PH_SKIP: begin
          st_d.phase = PH_OP;
          if (byteIn[7:1] == adc_cmd_pkg::OP_WAKE_HI) begin
            st_d.sleep = 1'b0;
          end else if (byteIn[7:1] == adc_cmd_pkg::OP_STANDBY_HI) begin
            st_d.sleep = 1'b1;
          end else if (byteIn[7:1] == adc_cmd_pkg::OP_ALIGN_HI) begin
            restart = alignLvl;
          end else if (byteIn[7:1] == adc_cmd_pkg::OP_SRESET_HI) begin
            softRst = 1'b1;
          end else if (byteIn == adc_cmd_pkg::OP_STREAM_ON) begin
            st_d.stream = 1'b1;
          end else if (byteIn == adc_cmd_pkg::OP_STREAM_OFF) begin
            st_d.stream = 1'b0;
          end else if (byteIn == adc_cmd_pkg::OP_SINGLE_READ) begin
            st_d.shiftOut = {st_q.sample, 8'h00};
            st_d.outBits = 6'd32;
          end else if (byteIn == adc_cmd_pkg::OP_ZERO_TRIM) begin
            st_d.trimOfs = 1'b1;
            st_d.trimCnt = 5'h0;
          end else if (byteIn == adc_cmd_pkg::OP_SPAN_TRIM) begin
            st_d.trimSpan = 1'b1;
            st_d.trimCnt = 5'h0;
          end else if (byteIn[7:5] == adc_cmd_pkg::OP_REG_READ_CMD_HI ||
                       byteIn[7:5] == adc_cmd_pkg::OP_REG_WRITE_CMD_HI) begin
            st_d.addr = byteIn[4:0];
            st_d.isRead = byteIn[7:5] == adc_cmd_pkg::OP_REG_READ_CMD_HI;
            st_d.phase = PH_COUNT;
          end
          // Other bytes fall through unchanged
        end
        PH_COUNT: begin
          st_d.left = byteIn[4:0];
          st_d.phase = st_q.isRead ? PH_RDATA : PH_WDATA;
          if (st_q.isRead) begin
            st_d.shiftOut = {rdByte, 24'h0};
            st_d.outBits = 6'd8;
          end
        end
        PH_WDATA: begin
          if (st_q.addr > adc_cmd_pkg::REG_IDENTITY &&
              st_q.addr != adc_cmd_pkg::REG_RESERVED_FIXED &&
              st_q.addr <= adc_cmd_pkg::REG_LAST) begin
            st_d.regs[st_q.addr*8 +: 8] = byteIn;
          end
          st_d.addr = st_q.addr + 5'h1;
          st_d.left = st_q.left - 5'h1;
          if (st_q.left == 5'h0) begin
            st_d.phase = PH_OP;
            restart = 1'b1;
            st_d.discard = 6'(adc_cmd_pkg::WRITE_RESTART_READINGS);
          end
        end
        PH_RDATA: begin
          st_d.addr = st_q.addr + 5'h1;
          st_d.left = st_q.left - 5'h1;
          if (st_q.left == 5'h0) begin
            st_d.phase = PH_OP;
          end else begin
            st_d.shiftOut = {(st_q.addr + 5'h1 <= adc_cmd_pkg::REG_LAST) ?
              st_q.regs[(st_q.addr + 5'h1)*8 +: 8] : 8'h00, 24'h0};
            st_d.outBits = 6'd8;
          end
        end
        default: begin
          st_d.phase = PH_OP;
        end
      endcase
    end
    if (restart) begin
      st_d.sampleTmr = 16'h0;
      st_d.readyN = 1'b1;
    end
    if (selFall && st_q.phase == PH_SAMPLE) begin
      st_d.phase = PH_SKIP;
    end
    st_d.regs[7:0] = adc_cmd_pkg::IDENTITY_VALUE;
    // Soft reset or power-down restore defaults
    if (softRst || !pdLvl) begin
      st_d = '0;
      st_d.phase = PH_OP;
      st_d.stream = 1'b1;
      st_d.readyN = 1'b1;
      st_d.regs = adc_cmd_pkg::REG_RESET;
      st_d.regs[7:0] = adc_cmd_pkg::IDENTITY_VALUE;
      // Mid-bit soft reset keeps the data line steady
      st_d.serOut = softRst ? st_q.serOut : 1'b0;
    end
    // Converting flag registered for the output
    st_d.conv = !st_d.sleep && st_d.discard == 6'h0;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
      st_q.phase <= PH_OP;
      st_q.stream <= 1'b1;
      st_q.readyN <= 1'b1;
      st_q.conv <= 1'b1;
      st_q.regs <= adc_cmd_pkg::REG_RESET;
    end else begin
      st_q <= st_d;
    end
  end
  assign link.serialOut = st_q.serOut;
  assign link.sampleReadyN = st_q.readyN;
  assign standby = st_q.sleep;
  assign converting = st_q.conv;
  assign offsetWord = st_q.regs[adc_cmd_pkg::REG_OFFSET_LOW*8 +: 24];
  assign spanWord = st_q.regs[adc_cmd_pkg::REG_SPAN_LOW*8 +: 24];
endmodule : adc_cmd_device
`default_nettype wire

// File: hw/adc_cmd_host.sv
// Host end: APB-controlled serial byte engine for the converter link
`timescale 1ns/1ns
`default_nettype none
module adc_cmd_host (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  adc_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} hstate_t;
  typedef struct packed {
    hstate_t st;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [3:0] bits;
    logic [2:0] div;
    logic sclk;
    logic sdo;
    logic selN;
    logic align;
    logic pdN;
    logic strap;
    logic [5:0] gap;
    logic hold;
    logic [31:0] rdata;
    logic ack;
    logic err;
  } host_t;
  host_t q;
  host_t d;
  logic rdyLvl, sdiLvl;
  sync_edge u_rdy (.sys_clk(sys_clk), .rst(rst), .din(link.sampleReadyN),
    .level(rdyLvl), .rise(), .fall());
  sync_edge u_sdi (.sys_clk(sys_clk), .rst(rst), .din(link.serialOut),
    .level(sdiLvl), .rise(), .fall());
  logic acc;
  // Byte shifter with enforced byte gap
  always_comb begin
    d = q;
    d.ack = 1'b0;
    d.err = 1'b0;
    acc = psel && penable && !q.ack;
    case (q.st)
      H_IDLE: begin
        d.sclk = 1'b0;
        if (!q.hold) begin
          d.selN = 1'b1;
        end
      end
      H_SHIFT: begin
        d.div = q.div + 3'h1;
        if (q.div == 3'(adc_cmd_pkg::LINK_DIV - 1)) begin
          d.div = 3'h0;
          d.sclk = ~q.sclk;
          if (!q.sclk) begin
            d.sdo = q.tx[7];
          end else begin
            d.rx = {q.rx[6:0], sdiLvl};
            d.tx = {q.tx[6:0], 1'b0};
            d.bits = q.bits - 4'h1;
            if (q.bits == 4'h1) begin
              d.st = H_GAP;
              d.gap = 6'(adc_cmd_pkg::BYTE_GAP_CYCLES);
            end
          end
        end
      end
      H_GAP: begin
        d.gap = q.gap - 6'h1;
        if (q.gap == 6'h1) begin
          d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
    // APB slave, one wait cycle
    if (acc) begin
      d.ack = 1'b1;
      d.rdata = 32'h0;
      if (pwrite) begin
        case (paddr)
          adc_cmd_pkg::APB_CTRL: begin
            d.align = pwdata[0];
            d.pdN = pwdata[1];
            d.strap = pwdata[2];
            d.hold = pwdata[3];
          end
          adc_cmd_pkg::APB_TXDATA: begin
            if (q.st == H_IDLE) begin
              d.tx = pwdata[7:0];
              d.bits = 4'h8;
              d.div = 3'h0;
              d.selN = 1'b0;
              d.st = H_SHIFT;
            end else begin
              d.err = 1'b1;
            end
          end
          default: d.err = 1'b1;
        endcase
      end else begin
        case (paddr)
          adc_cmd_pkg::APB_CTRL:
            d.rdata = {28'h0, q.hold, q.strap, q.pdN, q.align};
          adc_cmd_pkg::APB_STATUS:
            d.rdata = {30'h0, rdyLvl, q.st != H_IDLE};
          adc_cmd_pkg::APB_RXDATA: d.rdata = {24'h0, q.rx};
          default: d.err = 1'b1;
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= '0;
      q.st <= H_IDLE;
      q.selN <= 1'b1;
      q.pdN <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign prdata = q.rdata;
  assign pready = q.ack;
  assign pslverr = q.err;
  assign link.serialClk = q.sclk;
  assign link.serialIn = q.sdo;
  assign link.frameSelN = q.selN;
  assign link.alignPin = q.align;
  assign link.powerDownPinN = q.pdN;
  assign link.pinStrapSelect = q.strap;
endmodule : adc_cmd_host
`default_nettype wire

// File: bench/adc_link_chk.sv
// Checker: timing relations on the converter link wires
`timescale 1ns/1ns
`default_nettype none
module adc_link_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic frameSelN,
  input wire logic sampleReadyN,
  input wire logic alignPin,
  input wire logic powerDownPinN,
  input wire logic pinStrapSelect
);
  localparam int SP = adc_cmd_pkg::SAMPLE_PERIOD;
  logic clkPrev_q;
  logic clkSeen_q;
  logic rdyPrev_q;
  logic rdySeen_q;
  logic [2:0] bitCnt_q;
  logic [7:0] sinceRise_q;
  logic [11:0] sinceRdy_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Bit count and spacing counters
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clkPrev_q <= 1'b0;
      clkSeen_q <= 1'b0;
      rdyPrev_q <= 1'b1;
      rdySeen_q <= 1'b0;
      bitCnt_q <= 3'h0;
      sinceRise_q <= 8'h00;
      sinceRdy_q <= 12'h000;
    end else begin
      clkPrev_q <= serialClk;
      rdyPrev_q <= sampleReadyN;
      if (serialClk && !clkPrev_q) begin
        sinceRise_q <= 8'h00;
        bitCnt_q <= bitCnt_q + 3'h1;
        clkSeen_q <= 1'b1;
      end else if (sinceRise_q != 8'hff) begin
        sinceRise_q <= sinceRise_q + 8'h01;
      end
      if (!sampleReadyN && rdyPrev_q) begin
        sinceRdy_q <= 12'h000;
        rdySeen_q <= 1'b1;
      end else if (sinceRdy_q != 12'hfff) begin
        sinceRdy_q <= sinceRdy_q + 12'h001;
      end
    end
  end
  // Link wire relations
  a_ready_pulse: assert property ($fell(sampleReadyN) |=> sampleReadyN)
    else $error("ready low longer than one cycle");
  a_ready_space: assert property ($fell(sampleReadyN) && rdySeen_q
    |-> sinceRdy_q >= SP - 1) else $error("ready pulses too close");
  a_byte_gap: assert property ($rose(serialClk) && bitCnt_q == 3'h0
    && clkSeen_q |-> sinceRise_q >= 8'd23) else $error("byte gap short");
  a_clk_high: assert property ($rose(serialClk)
    |-> serialClk [*4] ##1 !serialClk) else $error("clock high phase");
  a_clk_inframe: assert property ($changed(serialClk) |-> !frameSelN)
    else $error("clock moves outside frame");
  a_clk_idle: assert property (frameSelN |-> !serialClk)
    else $error("clock not idle low");
  a_out_steady: assert property ($rose(serialClk)
    |=> $stable(serialOut) [*3]) else $error("data moved while high");
  a_reset_lines: assert property ($fell(rst)
    |-> sampleReadyN && frameSelN && powerDownPinN)
    else $error("lines wrong after reset");
  a_strap_idle: assert property ($fell(rst)
    |-> !pinStrapSelect && !alignPin && !serialClk)
    else $error("strap or align wrong after reset");
endmodule : adc_link_chk
`default_nettype wire

// File: bench/adc_spi_command_register_unit_tb.sv
// Testbench: host and converter ends joined over the serial link
`timescale 1ns/1ns
`default_nettype none
module adc_spi_command_register_unit_tb;
  localparam int SP = adc_cmd_pkg::SAMPLE_PERIOD;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] op;
    logic stby;
  } row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [23:0] sampleIn = 24'h123456;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic standby;
  logic converting;
  logic [23:0] offsetWord;
  logic [23:0] spanWord;
  logic [31:0] rd;
  logic [31:0] exp;
  logic er;
  int failCount = 0;
  int checkCount = 0;
  int lows = 0;
  // Control value, opcode, expected standby
  row_t rows [8] = '{'{8'h02, 8'h02, 1'b1}, '{8'h02, 8'h01, 1'b0},
    '{8'h02, 8'h00, 1'b0}, '{8'h02, 8'h03, 1'b1}, '{8'h06, 8'h00, 1'b1},
    '{8'h02, 8'h00, 1'b0}, '{8'h03, 8'h05, 1'b0}, '{8'h02, 8'h13, 1'b0}};
  adc_link_if link ();
  adc_cmd_host i_adc_cmd_host (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  adc_cmd_device i_adc_cmd_device (.sys_clk(sys_clk), .rst(rst),
    .link(link), .sampleIn(sampleIn), .standby(standby),
    .converting(converting), .offsetWord(offsetWord), .spanWord(spanWord));
  adc_link_chk i_adc_link_chk (.sys_clk(sys_clk), .rst(rst),
    .serialClk(link.serialClk), .serialIn(link.serialIn),
    .serialOut(link.serialOut), .frameSelN(link.frameSelN),
    .sampleReadyN(link.sampleReadyN), .alignPin(link.alignPin),
    .powerDownPinN(link.powerDownPinN),
    .pinStrapSelect(link.pinStrapSelect));
  // Clock
  always #50 sys_clk = ~sys_clk;
  // Cycles with the ready line low
  always @(posedge sys_clk) begin
    if (link.sampleReadyN === 1'b0) lows++;
  end
  task automatic results();
    if (failCount == 0 && checkCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [31:0] e,
    input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      failCount++;
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One link byte, then wait for idle
  task automatic send(input logic [7:0] b);
    apb(1'b1, adc_cmd_pkg::APB_TXDATA, {24'h0, b});
    do apb(1'b0, adc_cmd_pkg::APB_STATUS, 32'h0); while (rd[0] !== 1'b0);
  endtask : send
  // Watchdog
  initial begin
    repeat (40 * SP) @(posedge sys_clk);
    failCount++;
    results();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("standby", 32'h0, standby);
    chk("converting", 32'h1, converting);
    chk("offset", 32'h0, offsetWord);
    chk("span", 32'h400000, spanWord);
    lows = 0;
    repeat (2 * SP + 100) @(posedge sys_clk);
    chk("ready count", 32'h1, lows >= 2);
    send(adc_cmd_pkg::OP_ZERO_TRIM);
    repeat (17 * SP) @(posedge sys_clk);
    chk("trim", 32'h123456, offsetWord);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h1, er);
    send(adc_cmd_pkg::OP_STREAM_OFF);
    lows = 0;
    repeat (2 * SP + 100) @(posedge sys_clk);
    chk("stream off", 32'h0, lows);
    // Power and control opcodes, align pin high with align
    foreach (rows[i]) begin
      apb(1'b1, adc_cmd_pkg::APB_CTRL, {24'h0, rows[i].ctrl});
      send(rows[i].op);
      chk("standby", rows[i].stby, standby);
    end
    // Burst write of three offset bytes
    apb(1'b1, adc_cmd_pkg::APB_CTRL, 32'h0a);
    send(8'h45);
    send(8'h02);
    send(8'h11);
    send(8'h22);
    send(8'h33);
    apb(1'b1, adc_cmd_pkg::APB_CTRL, 32'h02);
    chk("offset", 32'h332211, offsetWord);
    chk("span", 32'h400000, spanWord);
    // Burst read from address zero, four registers
    apb(1'b1, adc_cmd_pkg::APB_CTRL, 32'h0a);
    send(adc_cmd_pkg::OP_REG_READ_CMD_BASE);
    send(8'h03);
    for (int i = 0; i < 4; i++) begin
      send(8'h00);
      apb(1'b0, adc_cmd_pkg::APB_RXDATA, 32'h0);
      exp = (i == 0) ? adc_cmd_pkg::IDENTITY_VALUE
        : adc_cmd_pkg::REG_RESET[8*i+:8];
      chk("read byte", exp, rd[7:0]);
    end
    apb(1'b1, adc_cmd_pkg::APB_CTRL, 32'h02);
    // Results held back after the write
    send(adc_cmd_pkg::OP_STREAM_ON);
    lows = 0;
    repeat (4 * SP) @(posedge sys_clk);
    chk("restart", 32'h0, lows);
    chk("converting", 32'h0, converting);
    // Power-down pin loses registers
    apb(1'b1, adc_cmd_pkg::APB_CTRL, 32'h00);
    repeat (10) @(posedge sys_clk);
    apb(1'b1, adc_cmd_pkg::APB_CTRL, 32'h02);
    repeat (10) @(posedge sys_clk);
    chk("power down", 32'h0, offsetWord);
    // Single write, then soft reset with bit zero set
    apb(1'b1, adc_cmd_pkg::APB_CTRL, 32'h0a);
    send(8'h48);
    send(8'h00);
    send(8'h99);
    apb(1'b1, adc_cmd_pkg::APB_CTRL, 32'h02);
    chk("span write", 32'h400099, spanWord);
    send(8'h07);
    chk("soft reset", 32'h400000, spanWord);
    results();
  end
endmodule : adc_spi_command_register_unit_tb
`default_nettype wire
